// [gsfn_frame_track.sv]
// gsfn_frame_track: holds header of one in-flight frame from start to outcome
// assumes start, ok and fail pulses come from phy logic on clk
`timescale 1ns/1ps
module gsfn_frame_track
  import gsfn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // frame events
  input wire logic start,
  input wire gsfn_hdr_t hdr,
  input wire logic ok,
  input wire logic fail,
  // held header
  output logic pending,
  output gsfn_hdr_t held
);
  logic pending_ff;
  gsfn_hdr_t held_ff;
  wire logic nxt_pending = start | (pending_ff & ~ok & ~fail);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pending_ff <= 1'h0;
      held_ff <= '0;
    end
    else
    begin
      pending_ff <= nxt_pending;
      if (start)
        held_ff <= hdr;
    end
  end

  assign pending = pending_ff;
  assign held = held_ff;
endmodule // gsfn_frame_track

// [gsfn_mgmt_model.sv]
// gsfn_mgmt_model: management side issuing group sync requests
// assumes the bench pulses go on a rising edge
`timescale 1ns/1ps
module gsfn_mgmt_model
  import gsfn_pkg::*;
(
  // bench side
  input wire logic clk,
  input wire logic go,
  input wire logic [GSFN_ADDR_W-1:0] grp,
  // block side
  output logic req_valid = 1'h0,
  output logic [GSFN_ADDR_W-1:0] req_group = 48'h0
);
  always @(posedge clk)
  begin
    req_valid <= go;
    req_group <= go ? grp : ~req_group;
  end
endmodule // gsfn_mgmt_model

// [gsfn_monitor.sv]
// gsfn_monitor: confirm and indication timing
// assumes a bind onto gsfn_top
`timescale 1ns/1ps
module gsfn_monitor
  import gsfn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request and confirm
  input wire logic req_valid,
  input wire logic [GSFN_ADDR_W-1:0] req_group,
  input wire logic cfm_valid,
  input wire gsfn_outcome_t cfm_outcome,
  input wire logic armed,
  // frame outcome and indication
  input wire logic tx_ok,
  input wire logic rx_ok,
  input wire logic ind_valid,
  input wire logic [1:0] ind_dir
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic bad = req_valid && !req_group[GSFN_IG_BIT];
  sequence req_taken_s;
    req_valid;
  endsequence
  sequence cfm_next_s;
    ##1 cfm_valid;
  endsequence
  sequence refused_next_s;
    ##1 (cfm_outcome == GSFN_UNSUPPORTED);
  endsequence
  cfm_once_a: assert property (req_taken_s |-> cfm_next_s) else $error("request without confirm");
  cfm_cause_a: assert property (cfm_valid |-> $past(req_valid)) else $error("confirm without request");
  bad_code_a: assert property (bad |-> refused_next_s) else $error("bad group not refused");
  bad_keep_a: assert property (bad |=> $stable(armed)) else $error("bad group changed arming");
  arm_ok_a: assert property (cfm_valid && cfm_outcome == GSFN_SUCCESS |-> armed) else $error("success not armed");
  ind_armed_a: assert property (ind_valid |-> $past(armed)) else $error("indication while unarmed");
  ind_ok_a: assert property (ind_valid |-> $past(tx_ok || rx_ok)) else $error("indication without ok");
  ind_dir_a: assert property (ind_valid |-> ind_dir != 2'h0) else $error("indication without direction");
  dir_quiet_a: assert property (!ind_valid |-> ind_dir == 2'h0) else $error("direction without indication");
endmodule // gsfn_monitor
bind gsfn_top gsfn_monitor i_gsfn_monitor (
  .clk(clk),
  .nrst(nrst),
  .req_valid(req_valid),
  .req_group(req_group),
  .cfm_valid(cfm_valid),
  .cfm_outcome(cfm_outcome),
  .armed(armed),
  .tx_ok(tx_ok),
  .rx_ok(rx_ok),
  .ind_valid(ind_valid),
  .ind_dir(ind_dir)
);

// [gsfn_pkg.sv]
// gsfn_pkg: types and constants for the group sync frame notifier
// assumes a single clock domain; frame events arrive from mac/phy logic on the same clock
package gsfn_pkg;
  localparam int GSFN_ADDR_W = 48;
  localparam int GSFN_SEQ_W = 12;
  localparam int GSFN_IG_BIT = 40;
  localparam logic [1:0] GSFN_TYPE_DATA = 2'h1;
  localparam logic [GSFN_ADDR_W-1:0] GSFN_ADDR_RST = 48'h0;

  typedef enum logic {GSFN_SUCCESS, GSFN_UNSUPPORTED} gsfn_outcome_t;

  typedef struct packed {
    logic [GSFN_ADDR_W-1:0] destination_address_field;
    logic [GSFN_ADDR_W-1:0] sender_address;
    logic [GSFN_SEQ_W-1:0] frame_sequence_count;
    logic [1:0] frame_type;
  } gsfn_hdr_t;

  typedef struct packed {
    logic [GSFN_ADDR_W-1:0] watched_group_address;
    logic [GSFN_ADDR_W-1:0] sender_address;
    logic [GSFN_SEQ_W-1:0] frame_sequence_count;
    logic is_tx;
  } gsfn_ind_t;

  function automatic logic gsfn_is_group(input logic [GSFN_ADDR_W-1:0] a);
    return a[GSFN_IG_BIT];
  endfunction
endpackage

// [gsfn_top.sv]
// gsfn_top: watches one multicast group and notifies on matching data frames
// assumes management requests and phy frame events are synchronous to clk
//
// Contract
// - accepted request arms watch on given group
// - one confirm per request, success or unsupported
// - unsupported and arming left unchanged if no feature/not multicast
// - notify matching data frames only when armed
// - notify only on phy-reported successful frames
// - notification issued the cycle after phy ok, header taken at frame start
// - notification carries group, sender, sequence count
`timescale 1ns/1ps
module gsfn_top
  import gsfn_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // feature strap
  input wire logic feature_en,
  // group_sync_primitive request and confirm
  input wire logic req_valid,
  input wire logic [GSFN_ADDR_W-1:0] req_group,
  output logic cfm_valid,
  output gsfn_outcome_t cfm_outcome,
  output logic armed,
  // transmit frame events
  input wire logic tx_start,
  input wire gsfn_hdr_t tx_hdr,
  input wire logic tx_ok,
  input wire logic tx_fail,
  // receive frame events
  input wire logic rx_start,
  input wire gsfn_hdr_t rx_hdr,
  input wire logic rx_ok,
  input wire logic rx_fail,
  // indication
  output logic ind_valid,
  output gsfn_ind_t ind,
  output logic [1:0] ind_dir
);
  // direction slots of the per-direction trackers
  localparam int GSFN_DIRS = 2;
  localparam int GSFN_DIR_TX = 0;
  localparam int GSFN_DIR_RX = 1;

  logic feat_s1_ff;
  logic feat_s2_ff;
  logic armed_ff;
  logic [GSFN_ADDR_W-1:0] registered_multicast_address_ff;
  logic cfm_valid_ff;
  gsfn_outcome_t cfm_outcome_ff;
  logic ind_valid_ff;
  gsfn_ind_t ind_ff;
  logic [1:0] ind_dir_ff;
  wire logic [GSFN_DIRS-1:0] dir_pend;
  wire logic [GSFN_DIRS-1:0] dir_match;
  wire logic [GSFN_DIRS-1:0] dir_hit;
  wire gsfn_hdr_t dir_hdr [GSFN_DIRS];
  wire gsfn_hdr_t dir_held [GSFN_DIRS];

  // feature strap is asynchronous, synchronise before use
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      feat_s1_ff <= 1'h0;
    end
    else
    begin
      feat_s1_ff <= feature_en;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      feat_s2_ff <= 1'h0;
    end
    else
    begin
      feat_s2_ff <= feat_s1_ff;
    end
  end

  // request check
  wire logic req_ok = feat_s2_ff & gsfn_is_group(req_group);
  wire logic take_req = req_valid & req_ok;
  wire gsfn_outcome_t verdict = req_ok ? GSFN_SUCCESS : GSFN_UNSUPPORTED;
  wire logic nxt_armed = take_req | armed_ff;
  wire logic [GSFN_ADDR_W-1:0] nxt_registered_multicast_address =
    take_req ? req_group : registered_multicast_address_ff;
  wire logic nxt_cfm_valid = req_valid;
  wire gsfn_outcome_t nxt_cfm_outcome = req_valid ? verdict : cfm_outcome_ff;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      armed_ff <= 1'h0;
    end
    else
    begin
      armed_ff <= nxt_armed;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      registered_multicast_address_ff <= GSFN_ADDR_RST;
    end
    else
    begin
      registered_multicast_address_ff <= nxt_registered_multicast_address;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfm_valid_ff <= 1'h0;
    end
    else
    begin
      cfm_valid_ff <= nxt_cfm_valid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfm_outcome_ff <= GSFN_SUCCESS;
    end
    else
    begin
      cfm_outcome_ff <= nxt_cfm_outcome;
    end
  end

  // frame events gathered per direction
  wire logic [GSFN_DIRS-1:0] dir_start = {rx_start, tx_start};
  wire logic [GSFN_DIRS-1:0] dir_ok = {rx_ok, tx_ok};
  wire logic [GSFN_DIRS-1:0] dir_fail = {rx_fail, tx_fail};
  assign dir_hdr[GSFN_DIR_TX] = tx_hdr;
  assign dir_hdr[GSFN_DIR_RX] = rx_hdr;

  // match decode
  function automatic logic gsfn_match(input gsfn_hdr_t h, input logic [GSFN_ADDR_W-1:0] g);
    return (h.frame_type == GSFN_TYPE_DATA) && (h.destination_address_field == g);
  endfunction

  // header captured at frame start on the medium
  for (genvar d = 0; d < GSFN_DIRS; d++)
  begin : g_dir
    gsfn_frame_track u_track (
      .clk(clk),
      .nrst(nrst),
      .start(dir_start[d]),
      .hdr(dir_hdr[d]),
      .ok(dir_ok[d]),
      .fail(dir_fail[d]),
      .pending(dir_pend[d]),
      .held(dir_held[d])
    );
    assign dir_match[d] = gsfn_match(dir_held[d], registered_multicast_address_ff);
    assign dir_hit[d] = armed_ff & dir_pend[d] & dir_ok[d] & dir_match[d];
  end

  // indication build, transmit fills the payload when both hit
  wire logic tx_hit = dir_hit[GSFN_DIR_TX];
  wire logic any_hit = |dir_hit;
  wire gsfn_hdr_t sel_hdr = tx_hit ? dir_held[GSFN_DIR_TX] : dir_held[GSFN_DIR_RX];
  wire gsfn_ind_t hit_report = '{
    watched_group_address: registered_multicast_address_ff,
    sender_address: sel_hdr.sender_address,
    frame_sequence_count: sel_hdr.frame_sequence_count,
    is_tx: tx_hit
  };
  wire logic nxt_ind_valid = any_hit;
  wire gsfn_ind_t nxt_ind = any_hit ? hit_report : ind_ff;
  wire logic [1:0] nxt_ind_dir = dir_hit;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ind_valid_ff <= 1'h0;
    end
    else
    begin
      ind_valid_ff <= nxt_ind_valid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ind_ff <= '0;
    end
    else
    begin
      ind_ff <= nxt_ind;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ind_dir_ff <= 2'h0;
    end
    else
    begin
      ind_dir_ff <= nxt_ind_dir;
    end
  end

  assign armed = armed_ff;
  assign cfm_valid = cfm_valid_ff;
  assign cfm_outcome = cfm_outcome_ff;
  assign ind_valid = ind_valid_ff;
  assign ind = ind_ff;
  assign ind_dir = ind_dir_ff;
endmodule // gsfn_top

// [test_group_sync_frame_notifier.sv]
// test_group_sync_frame_notifier: arming and notification
// assumes gsfn_top and the models compiled first
`timescale 1ns/1ps
module test_group_sync_frame_notifier
  import gsfn_pkg::*;
;
  localparam logic [47:0] GRP = 48'h0100_0000_0007;
  localparam gsfn_hdr_t HT = {GRP, 48'h0A00_0000_00A5, 12'h3C5, GSFN_TYPE_DATA};
  logic clk = 1'h0, nrst = 1'h0, feature_en = 1'h1, go = 1'h0, req_valid, cfm_valid, armed, ind_valid;
  logic tx_start = 1'h0, rx_start = 1'h0, tx_ok = 1'h0, rx_ok = 1'h0, tx_fail = 1'h0, rx_fail = 1'h0;
  logic [47:0] grp = 48'h0, req_group;
  logic [1:0] ind_dir;
  gsfn_outcome_t cfm_outcome;
  gsfn_ind_t ind;
  gsfn_hdr_t tx_hdr = HT, rx_hdr = HT;
  int err_total = 0, tests_run = 0;
  gsfn_top i_gsfn_top (
    .clk(clk),
    .nrst(nrst),
    .feature_en(feature_en),
    .req_valid(req_valid),
    .req_group(req_group),
    .cfm_valid(cfm_valid),
    .cfm_outcome(cfm_outcome),
    .armed(armed),
    .tx_start(tx_start),
    .tx_hdr(tx_hdr),
    .tx_ok(tx_ok),
    .tx_fail(tx_fail),
    .rx_start(rx_start),
    .rx_hdr(rx_hdr),
    .rx_ok(rx_ok),
    .rx_fail(rx_fail),
    .ind_valid(ind_valid),
    .ind(ind),
    .ind_dir(ind_dir)
  );
  gsfn_mgmt_model i_gsfn_mgmt_model (
    .clk(clk),
    .go(go),
    .grp(grp),
    .req_valid(req_valid),
    .req_group(req_group)
  );
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [109:0] s, input logic [109:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_total++;
      $display("[FAIL] %0t %h %h", $time, s, x);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_req(input logic [47:0] g, input gsfn_outcome_t o, input logic a);
    go <= 1'h1;
    grp <= g;
    @(posedge clk) go <= 1'h0;
    @(posedge clk) #1;
    chk(cfm_valid, 1'h1);
    chk(cfm_outcome, o);
    chk(armed, a);
    @(posedge clk);
  endtask
  task automatic frame(input logic [1:0] d, input gsfn_hdr_t h, input logic good, input logic e);
    {rx_start, tx_start} <= d;
    tx_hdr <= h;
    rx_hdr <= h;
    @(posedge clk) {rx_start, tx_start} <= 2'h0;
    @(posedge clk) {rx_ok, tx_ok, rx_fail, tx_fail} <= good ? {d, 2'h0} : {2'h0, d};
    @(posedge clk) {rx_ok, tx_ok, rx_fail, tx_fail} <= 4'h0;
    #1;
    chk(ind_valid, e);
    chk(ind_dir, e ? d : 2'h0);
    if (e)
      chk(ind, {GRP, h.sender_address, h.frame_sequence_count, d[0]});
    @(posedge clk);
  endtask
  task automatic t_arm;
    do_req(GRP ^ 48'h0100_0000_0000, GSFN_UNSUPPORTED, 1'h0);
    frame(2'h1, HT, 1'h1, 1'h0);
    do_req(GRP, GSFN_SUCCESS, 1'h1);
    $display("t_arm done");
  endtask
  task automatic t_frames;
    frame(2'h1, HT, 1'h1, 1'h1);
    frame(2'h2, HT, 1'h1, 1'h1);
    frame(2'h2, HT, 1'h0, 1'h0);
    frame(2'h1, HT ^ 110'h3, 1'h1, 1'h0);
    do_req(48'h0, GSFN_UNSUPPORTED, 1'h1);
    frame(2'h3, HT, 1'h1, 1'h1);
    $display("t_frames done");
  endtask
  task automatic t_reset;
    nrst <= 1'h0;
    feature_en <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(armed, 1'h0);
    chk(cfm_valid, 1'h0);
    chk(cfm_outcome, GSFN_SUCCESS);
    chk(ind_valid, 1'h0);
    chk(ind_dir, 2'h0);
    @(posedge clk) nrst <= 1'h1;
    repeat (3) @(posedge clk);
    do_req(GRP, GSFN_UNSUPPORTED, 1'h0);
    frame(2'h1, HT, 1'h1, 1'h0);
    feature_en <= 1'h1;
    repeat (3) @(posedge clk);
    do_req(GRP, GSFN_SUCCESS, 1'h1);
    frame(2'h2, HT, 1'h1, 1'h1);
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    t_arm;
    t_frames;
    t_reset;
    end_of_test;
  end
  initial
  begin
    #2000;
    err_total++;
    end_of_test;
  end
endmodule // test_group_sync_frame_notifier
